// ==== src/wcr_regs.sv ====
`default_nettype none
module wcr_regs
  import wcr_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               clk_en,
  input  wire wcr_req_type        req,
  output logic [7:0]              rdata_q,
  output logic                    rvalid_q,
  input  wire logic [1:0]         sample_valid,
  input  wire logic [1:0][11:0]   sample,
  output logic [1:0]              alert_high,
  output logic [1:0]              alert_low,
  output logic                    comparator_block_on
);
  logic             block_on_q;
  logic [1:0]       alarm_on_q;
  logic [1:0][7:0]  up_byte_q;
  logic [1:0][3:0]  up_nib_q;
  logic [1:0][7:0]  lo_byte_q;
  logic [1:0][3:0]  lo_nib_q;
  logic [1:0][5:0]  hys_q;
  logic [7:0]       rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic en);
    hit = en && (a == b);
  endfunction

  wire w_en   = hit(req.addr, WCR_ADDR_WC_ENABLE, req.wr);
  wire w_alm  = hit(req.addr, WCR_ADDR_CHAN_ALARM_EN, req.wr);
  assign comparator_block_on = block_on_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      block_on_q <= 1'b0;
      alarm_on_q <= WCR_RST_ALARM_ON;
    end else if (clk_en) begin
      if (w_en) begin
        block_on_q <= req.wdata[0];
      end
      if (w_alm) begin
        alarm_on_q <= req.wdata[1:0];
      end
    end
  end

  // Each channel's register addresses are chosen by a per-channel select, so one loop serves both channels.
  genvar c;
  generate
    for (c = 0; c < WCR_NCHAN; c++) begin : g_chan
      logic [7:0] a_ub;
      logic [7:0] a_un;
      logic [7:0] a_lb;
      logic [7:0] a_ln;
      logic [7:0] a_hy;
      wcr_chan_cfg_type cfg;
      assign a_ub = (c == 0) ? WCR_ADDR_C0_UP_BYTE : WCR_ADDR_C1_UP_BYTE;
      assign a_un = (c == 0) ? WCR_ADDR_C0_UP_NIB  : WCR_ADDR_C1_UP_NIB;
      assign a_lb = (c == 0) ? WCR_ADDR_C0_LO_BYTE : WCR_ADDR_C1_LO_BYTE;
      assign a_ln = (c == 0) ? WCR_ADDR_C0_LO_NIB  : WCR_ADDR_C1_LO_NIB;
      assign a_hy = (c == 0) ? WCR_ADDR_C0_HYS     : WCR_ADDR_C1_HYS;
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          up_byte_q[c] <= WCR_RST_BYTE;
          up_nib_q[c]  <= WCR_RST_NIB;
          lo_byte_q[c] <= WCR_RST_BYTE;
          lo_nib_q[c]  <= WCR_RST_NIB;
          hys_q[c]     <= WCR_RST_HYS;
        end else if (clk_en) begin
          if (hit(req.addr, a_ub, req.wr)) begin
            up_byte_q[c] <= req.wdata;
          end
          if (hit(req.addr, a_un, req.wr)) begin
            up_nib_q[c] <= req.wdata[3:0];
          end
          if (hit(req.addr, a_lb, req.wr)) begin
            lo_byte_q[c] <= req.wdata;
          end
          if (hit(req.addr, a_ln, req.wr)) begin
            lo_nib_q[c] <= req.wdata[3:0];
          end
          if (hit(req.addr, a_hy, req.wr)) begin
            hys_q[c] <= req.wdata[5:0];
          end
        end
      end
      assign cfg.upper    = {up_nib_q[c], up_byte_q[c]};
      assign cfg.lower    = {lo_nib_q[c], lo_byte_q[c]};
      assign cfg.hys      = hys_q[c];
      assign cfg.alarm_on = alarm_on_q[c];
      wcr_window_cmp u_cmp (
        .clock        (clock),
        .rstn         (rstn),
        .clk_en       (clk_en),
        .block_on     (block_on_q),
        .cfg          (cfg),
        .sample_valid (sample_valid[c]),
        .sample       (sample[c]),
        .alert_high_q (alert_high[c]),
        .alert_low_q  (alert_low[c])
      );
    end
  endgenerate

  // Unmapped addresses read as zero; reserved bits are padded with zero.
  assign rd_mux =
    (req.addr == WCR_ADDR_WC_ENABLE)     ? {7'h00, block_on_q} :
    (req.addr == WCR_ADDR_CHAN_ALARM_EN) ? {6'h00, alarm_on_q} :
    (req.addr == WCR_ADDR_C0_UP_BYTE)    ? up_byte_q[0] :
    (req.addr == WCR_ADDR_C0_UP_NIB)     ? {4'h0, up_nib_q[0]} :
    (req.addr == WCR_ADDR_C0_LO_BYTE)    ? lo_byte_q[0] :
    (req.addr == WCR_ADDR_C0_LO_NIB)     ? {4'h0, lo_nib_q[0]} :
    (req.addr == WCR_ADDR_C1_UP_BYTE)    ? up_byte_q[1] :
    (req.addr == WCR_ADDR_C1_UP_NIB)     ? {4'h0, up_nib_q[1]} :
    (req.addr == WCR_ADDR_C1_LO_BYTE)    ? lo_byte_q[1] :
    (req.addr == WCR_ADDR_C1_LO_NIB)     ? {4'h0, lo_nib_q[1]} :
    (req.addr == WCR_ADDR_C0_HYS)        ? {2'h0, hys_q[0]} :
    (req.addr == WCR_ADDR_C1_HYS)        ? {2'h0, hys_q[1]} :
    8'h00;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q  <= WCR_RST_BYTE;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Write checks compare with the bus word one cycle back, so a freeze just after the write cannot upset them.
  AST_EN_WRITE: assert property (
    clk_en && w_en |=> comparator_block_on == $past(req.wdata[0]))
    else $error("Global enable did not follow write.");
  AST_EN_RDZERO: assert property (
    clk_en && req.rd && req.addr == WCR_ADDR_WC_ENABLE |=> rdata_q[7:1] == 7'h00)
    else $error("Enable register reserved bits not zero.");
  AST_ALM_WRITE: assert property (
    clk_en && w_alm |=> alarm_on_q == $past(req.wdata[1:0]))
    else $error("Channel alarm enables did not follow write.");
  AST_ALM_RDZERO: assert property (
    clk_en && req.rd && req.addr == WCR_ADDR_CHAN_ALARM_EN |=> rdata_q[7:2] == 6'h00)
    else $error("Alarm register reserved bits not zero.");
  AST_NIB_RDZERO: assert property (
    clk_en && req.rd && req.addr[7:4] == 4'h3 && req.addr[0] && req.addr[3] |=> rdata_q[7:4] == 4'h0)
    else $error("Limit nibble reserved bits not zero.");
  AST_HYS_RDZERO: assert property (
    clk_en && req.rd && (req.addr == WCR_ADDR_C0_HYS || req.addr == WCR_ADDR_C1_HYS) |=> rdata_q[7:6] == 2'h0)
    else $error("Hysteresis reserved bits not zero.");
  AST_UP0_WRITE: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C0_UP_NIB, req.wr) |=> up_nib_q[0] == $past(req.wdata[3:0]))
    else $error("Channel zero upper nibble not stored.");
  AST_UP0_BYTE: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C0_UP_BYTE, req.wr) |=> up_byte_q[0] == $past(req.wdata))
    else $error("Channel zero upper byte not stored.");
  AST_LO0_NIB: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C0_LO_NIB, req.wr) |=> lo_nib_q[0] == $past(req.wdata[3:0]))
    else $error("Channel zero lower nibble not stored.");
  AST_LO0_BYTE: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C0_LO_BYTE, req.wr) |=> lo_byte_q[0] == $past(req.wdata))
    else $error("Channel zero lower byte not stored.");
  AST_UP1_NIB: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C1_UP_NIB, req.wr) |=> up_nib_q[1] == $past(req.wdata[3:0]))
    else $error("Channel one upper nibble not stored.");
  AST_UP1_BYTE: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C1_UP_BYTE, req.wr) |=> up_byte_q[1] == $past(req.wdata))
    else $error("Channel one upper byte not stored.");
  AST_LO1_NIB: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C1_LO_NIB, req.wr) |=> lo_nib_q[1] == $past(req.wdata[3:0]))
    else $error("Channel one lower nibble not stored.");
  AST_LO1_WRITE: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C1_LO_BYTE, req.wr) |=> lo_byte_q[1] == $past(req.wdata))
    else $error("Channel one lower byte not stored.");
  AST_HYS0_WRITE: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C0_HYS, req.wr) |=> hys_q[0] == $past(req.wdata[5:0]))
    else $error("Channel zero hysteresis not stored.");
  AST_HYS1_WRITE: assert property (
    clk_en && hit(req.addr, WCR_ADDR_C1_HYS, req.wr) |=> hys_q[1] == $past(req.wdata[5:0]))
    else $error("Channel one hysteresis not stored.");
  AST_OFF_QUIET: assert property (
    clk_en && !block_on_q |=> alert_high == 2'h0 && alert_low == 2'h0)
    else $error("Alert raised while comparator is off.");
  AST_CHAN_QUIET: assert property (
    clk_en && !alarm_on_q[0] |=> !alert_high[0] && !alert_low[0])
    else $error("Channel zero alert while blocked.");
  AST_CHAN1_QUIET: assert property (
    clk_en && !alarm_on_q[1] |=> !alert_high[1] && !alert_low[1])
    else $error("Channel one alert while blocked.");
  AST_HIGH_TRIP: assert property (
    clk_en && block_on_q && alarm_on_q[0] && sample_valid[0] && !alert_high[0]
    && sample[0] > {up_nib_q[0], up_byte_q[0]} |=> alert_high[0])
    else $error("Channel zero high alert missed.");
  AST_LOW_TRIP: assert property (
    clk_en && block_on_q && alarm_on_q[1] && sample_valid[1] && !alert_low[1]
    && sample[1] < {lo_nib_q[1], lo_byte_q[1]} |=> alert_low[1])
    else $error("Channel one low alert missed.");
  COV_WRITE_EN: cover property (clk_en && w_en && req.wdata[0]);
  COV_HIGH: cover property (alert_high[0]);
  COV_LOW: cover property (alert_low[1]);
  COV_HIGH1: cover property (alert_high[1]);
endmodule // wcr_regs
`default_nettype wire

// ==== src/wcr_pkg.sv ====
`default_nettype none
package wcr_pkg;
  localparam logic [7:0] WCR_ADDR_CHAN_ALARM_EN = 8'h34;
  localparam logic [7:0] WCR_ADDR_WC_ENABLE     = 8'h37;
  localparam logic [7:0] WCR_ADDR_C0_UP_BYTE    = 8'h38;
  localparam logic [7:0] WCR_ADDR_C0_UP_NIB     = 8'h39;
  localparam logic [7:0] WCR_ADDR_C0_LO_BYTE    = 8'h3a;
  localparam logic [7:0] WCR_ADDR_C0_LO_NIB     = 8'h3b;
  localparam logic [7:0] WCR_ADDR_C1_UP_BYTE    = 8'h3c;
  localparam logic [7:0] WCR_ADDR_C1_UP_NIB     = 8'h3d;
  localparam logic [7:0] WCR_ADDR_C1_LO_BYTE    = 8'h3e;
  localparam logic [7:0] WCR_ADDR_C1_LO_NIB     = 8'h3f;
  localparam logic [7:0] WCR_ADDR_C0_HYS        = 8'h40;
  localparam logic [7:0] WCR_ADDR_C1_HYS        = 8'h41;
  localparam logic [7:0] WCR_RST_BYTE           = 8'h00;
  localparam logic [3:0] WCR_RST_NIB            = 4'h0;
  localparam logic [5:0] WCR_RST_HYS            = 6'h00;
  localparam logic [1:0] WCR_RST_ALARM_ON       = 2'h0;
  localparam int         WCR_NCHAN              = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wcr_req_type;

  typedef struct packed {
    logic [11:0] upper;
    logic [11:0] lower;
    logic [5:0]  hys;
    logic        alarm_on;
  } wcr_chan_cfg_type;
endpackage
`default_nettype wire

// ==== src/wcr_window_cmp.sv ====
`default_nettype none
module wcr_window_cmp
  import wcr_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  input  wire logic             block_on,
  input  wire wcr_chan_cfg_type cfg,
  input  wire logic             sample_valid,
  input  wire logic [11:0]      sample,
  output logic                  alert_high_q,
  output logic                  alert_low_q
);
  // Hysteresis releases an active alert only once the sample is back inside by the band.
  // The band is added rather than subtracted (to the sample on the high side, to the lower limit on the low side), so a band wider than the limit cannot wrap.
  logic [12:0] up_rel;
  logic [12:0] lo_rel;
  logic        armed;
  logic        high_d;
  logic        low_d;
  assign up_rel = {1'b0, sample} + {7'h00, cfg.hys};
  assign lo_rel = {1'b0, cfg.lower} + {7'h00, cfg.hys};
  assign armed  = block_on & cfg.alarm_on;
  assign high_d = !armed ? 1'b0 :
                  !sample_valid ? alert_high_q :
                  (alert_high_q ? (up_rel > {1'b0, cfg.upper}) : (sample > cfg.upper));
  assign low_d  = !armed ? 1'b0 :
                  !sample_valid ? alert_low_q :
                  (alert_low_q ? ({1'b0, sample} < lo_rel) : (sample < cfg.lower));
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alert_high_q <= 1'b0;
      alert_low_q  <= 1'b0;
    end else if (clk_en) begin
      alert_high_q <= high_d;
      alert_low_q  <= low_d;
    end
  end
endmodule // wcr_window_cmp
`default_nettype wire

// ==== testbench/wcr_host_model.sv ====
`default_nettype none
module wcr_host_model
  import wcr_pkg::*;
(
  input  wire logic        clock,
  output var  wcr_req_type req,
  input  wire logic [7:0]  rdata_q,
  input  wire logic        rvalid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // Requests launch on the falling edge so the taking rising edge sees them settled.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    req <= '0;
  endtask
  // The answer is registered, so it stands during the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    req <= '0;
    ok = rvalid_q;
    d = rdata_q;
  endtask
endmodule // wcr_host_model
`default_nettype wire

// ==== testbench/wcr_regs_tb.sv ====
`default_nettype none
module wcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wcr_pkg::*;
  logic             clock        = 1'b0;
  logic             rstn         = 1'b0;
  logic             clk_en       = 1'b1;
  logic [1:0]       sample_valid = 2'b00;
  logic [1:0][11:0] sample       = '0;
  wcr_req_type      req;
  logic [7:0]       rdata_q;
  logic             rvalid_q;
  logic [1:0]       alert_high;
  logic [1:0]       alert_low;
  logic             comparator_block_on;
  int               n_errors     = 0;
  int               comparisons  = 0;
  logic [7:0]       addrs [12]   = '{8'h34, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b,
                                     8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41};
  logic [7:0]       masks [12]   = '{8'h03, 8'h01, 8'hff, 8'h0f, 8'hff, 8'h0f,
                                     8'hff, 8'h0f, 8'hff, 8'h0f, 8'h3f, 8'h3f};

  always #4 clock = ~clock;

  wcr_regs i_wcr_regs (.clock(clock), .rstn(rstn), .clk_en(clk_en), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .sample_valid(sample_valid), .sample(sample), .alert_high(alert_high),
    .alert_low(alert_low), .comparator_block_on(comparator_block_on));
  wcr_host_model i_wcr_host_model (.clock(clock), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_wcr_host_model.rd(a, d, ok);
    chk1(ok, 1'b1);
    chk8(d, exp);
  endtask
  // Alerts are levels, so looking two edges after the pulse covers the one-cycle answer.
  task automatic pulse(input int ch, input logic [11:0] v);
    @(negedge clock);
    sample[ch] = v;
    sample_valid[ch] = 1'b1;
    @(negedge clock);
    sample_valid = 2'b00;
    @(negedge clock);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    final_report;
  end

  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 12; i++) rd_chk(addrs[i], 8'h00);
    for (int i = 0; i < 12; i++) begin
      i_wcr_host_model.wr(addrs[i], 8'hff);
      rd_chk(addrs[i], masks[i]);
    end
    chk1(comparator_block_on, 1'b1);
    i_wcr_host_model.wr(8'h35, 8'hff);
    rd_chk(8'h35, 8'h00);
    for (int i = 0; i < 12; i++) i_wcr_host_model.wr(addrs[i], 8'h00);
    i_wcr_host_model.wr(8'h39, 8'h01);
    i_wcr_host_model.wr(8'h38, 8'h23);
    i_wcr_host_model.wr(8'h40, 8'h04);
    i_wcr_host_model.wr(8'h3f, 8'h02);
    i_wcr_host_model.wr(8'h3d, 8'h0f);
    i_wcr_host_model.wr(8'h3c, 8'hff);
    i_wcr_host_model.wr(8'h34, 8'h03);
    i_wcr_host_model.wr(8'h37, 8'h01);
    pulse(0, 12'h123);
    chk1(alert_high[0], 1'b0);
    pulse(0, 12'h124);
    chk1(alert_high[0], 1'b1);
    pulse(0, 12'h120);
    chk1(alert_high[0], 1'b1);
    pulse(0, 12'h11f);
    chk1(alert_high[0], 1'b0);
    pulse(1, 12'h1ff);
    chk1(alert_low[1], 1'b1);
    i_wcr_host_model.wr(8'h34, 8'h01);
    repeat (2) @(negedge clock);
    chk1(alert_low[1], 1'b0);
    pulse(0, 12'h124);
    chk1(alert_high[0], 1'b1);
    i_wcr_host_model.wr(8'h37, 8'h00);
    repeat (2) @(negedge clock);
    chk1(alert_high[0], 1'b0);
    chk1(comparator_block_on, 1'b0);
    pulse(0, 12'h130);
    chk1(alert_high[0], 1'b0);
    // Low side of channel zero and high side of channel one, each with its own band.
    i_wcr_host_model.wr(8'h37, 8'h01);
    i_wcr_host_model.wr(8'h34, 8'h03);
    i_wcr_host_model.wr(8'h3a, 8'h10);
    pulse(0, 12'h00f);
    chk1(alert_low[0], 1'b1);
    pulse(0, 12'h013);
    chk1(alert_low[0], 1'b1);
    pulse(0, 12'h014);
    chk1(alert_low[0], 1'b0);
    i_wcr_host_model.wr(8'h3d, 8'h08);
    i_wcr_host_model.wr(8'h3c, 8'h00);
    i_wcr_host_model.wr(8'h41, 8'h10);
    pulse(1, 12'h801);
    chk1(alert_high[1], 1'b1);
    pulse(1, 12'h7f1);
    chk1(alert_high[1], 1'b1);
    pulse(1, 12'h7f0);
    chk1(alert_high[1], 1'b0);
    // A write offered while the clock enable is low must not land.
    clk_en = 1'b0;
    i_wcr_host_model.wr(8'h41, 8'h2a);
    clk_en = 1'b1;
    rd_chk(8'h41, 8'h10);
    // A reset in mid-run must bring written registers back to zero.
    rstn = 1'b0;
    @(negedge clock);
    rstn = 1'b1;
    chk1(comparator_block_on, 1'b0);
    rd_chk(8'h34, 8'h00);
    rd_chk(8'h3d, 8'h00);
    rd_chk(8'h41, 8'h00);
    final_report;
  end
endmodule // wcr_regs_tb
`default_nettype wire
